/* hw/dtc_pkg.sv */
// dtc_pkg: register map, field positions and types of the dual timer/counter pair
package dtc_pkg;

    // register offsets on the special-register port
    localparam logic [7:0] ADDR_CTRL = 8'h88;
    localparam logic [7:0] ADDR_MODE = 8'h89;
    localparam logic [7:0] ADDR_T0L = 8'h8a;
    localparam logic [7:0] ADDR_T1L = 8'h8b;
    localparam logic [7:0] ADDR_T0H = 8'h8c;
    localparam logic [7:0] ADDR_T1H = 8'h8d;

    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // timer_run_flag_ctrl bit positions
    localparam int B_TF1 = 7;
    localparam int B_TR1 = 6;
    localparam int B_TF0 = 5;
    localparam int B_TR0 = 4;
    localparam int B_IE1 = 3;
    localparam int B_IT1 = 2;
    localparam int B_IE0 = 1;
    localparam int B_IT0 = 0;

    // timer_mode_config: unit 1 config sits in the upper nibble
    localparam int CFG0_LSB = 0;
    localparam int CFG1_LSB = 4;

    // mode field encodings
    localparam logic [1:0] MODE_13 = 2'h0;
    localparam logic [1:0] MODE_16 = 2'h1;
    localparam logic [1:0] MODE_8R = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;

    // 13-bit mode: low byte prescaler width
    localparam logic [4:0] PRE_MAX = 5'h1f;

    // timing: oscillator is core_clk, one machine tick per twelve periods
    localparam int OSC_HZ = 50_000_000;
    localparam int TICK_DIV = 12;
    localparam logic [3:0] TICK_LAST = 4'(TICK_DIV - 1);

    // pin index into the sampler vector
    localparam int NPIN = 4;
    localparam int PIN_C0 = 0;
    localparam int PIN_C1 = 1;
    localparam int PIN_INT0 = 2;
    localparam int PIN_INT1 = 3;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] data;
    } dtc_sfr_req_t;

    typedef struct packed {
        logic gate;
        logic count_sel;
        logic [1:0] mode;
    } dtc_unit_cfg_t;

endpackage : dtc_pkg

/* hw/dtc_pin_sampler.sv */
// dtc_pin_sampler: pin synchronisers, per-clock and per-tick falling edge detection
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_sampler import dtc_pkg::*; (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic tick,
    input wire logic [NPIN-1:0] pins,
    output logic [NPIN-1:0] lvl,
    output logic [NPIN-1:0] lvl_fell,
    output logic [NPIN-1:0] smp_fell
);

    logic [NPIN-1:0] meta_q;
    logic [NPIN-1:0] sync_q;
    logic [NPIN-1:0] last_q;
    logic [NPIN-1:0] smp_q;
    logic [NPIN-1:0] old_q;

    genvar i;
    generate
        for (i = 0; i < NPIN; i++) begin : g_pin
            always_ff @(posedge core_clk or negedge arst_n) begin
                if (!arst_n) begin
                    meta_q[i] <= 1'b1;
                    sync_q[i] <= 1'b1;
                    last_q[i] <= 1'b1;
                    smp_q[i] <= 1'b1;
                    old_q[i] <= 1'b1;
                end else begin
                    meta_q[i] <= pins[i];
                    sync_q[i] <= meta_q[i];
                    last_q[i] <= sync_q[i];
                    // one sample per machine tick; a short pulse between ticks is missed
                    if (tick) begin
                        smp_q[i] <= sync_q[i];
                        old_q[i] <= smp_q[i];
                    end
                end
            end
            assign lvl[i] = sync_q[i];
            assign lvl_fell[i] = last_q[i] & ~sync_q[i];
            // high sample then low sample; consumed at the following tick
            assign smp_fell[i] = old_q[i] & ~smp_q[i];
        end
    endgenerate

endmodule : dtc_pin_sampler
`default_nettype wire

/* hw/dtc_timer_pair.sv */
// dtc_timer_pair: two 16-bit timer/counters with shared control and mode registers
//
// Contract
// [RL1] timer function increments once per twelve clocks
// [RL2] tick comes straight from oscillator divider
// [RL3] count pin sampled per tick, fall counted next
// [RL4] edge counting limited to one per 24
// [RL5] source holds each pin level one sample
// [RL6] overflow flag set by hardware, cleared on service
// [RL7] run bit switches its unit on or off
// [RL8] external flag set on active pin, service clears
// [RL9] trigger select: 1 falling edge, 0 low
// [RL10] gate bit requires run and high pin
// [RL11] function select: 0 timer, 1 pin counter
// [RL12] mode field picks 13, 16, reload, split
// [RL13] 13-bit uses high byte plus low five
// [RL14] 13-bit rollover sets overflow flag
// [RL15] setting run bit leaves count untouched
// [RL16] 16-bit mode cascades both bytes, no prescaler
// [RL17] reload mode: low byte reloads from high
// [RL18] unit one in mode three holds count
// [RL19] split: high byte ticks using unit one bits
// [RL20] split: unit one toggled by its mode
`timescale 1ns/1ps
`default_nettype none
module dtc_timer_pair import dtc_pkg::*; (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire dtc_sfr_req_t sfr_req,
    input wire logic t0_irq_ack,
    input wire logic t1_irq_ack,
    input wire logic ext0_irq_ack,
    input wire logic ext1_irq_ack,
    input wire logic count_pin_zero,
    input wire logic count_pin_one,
    input wire logic ext_irq_pin_zero,
    input wire logic ext_irq_pin_one,
    output logic [7:0] rd_data_q,
    output logic t0_overflow_flag,
    output logic t1_overflow_flag,
    output logic ext_irq0_flag,
    output logic ext_irq1_flag,
    output logic t0_ovf_pulse_q,
    output logic t1_ovf_pulse_q
);

    ////////////////////////////////////////////////////////////////////////////////
    // counter step for modes 13, 16, reload; split low byte falls to default

    function automatic logic [16:0] dtc_step(input logic [1:0] m, input logic [15:0] c);
        logic [16:0] r;
        r = {1'b0, c};
        unique case (m)
            MODE_13: begin
                r[4:0] = c[4:0] + 5'h01; // [RL13]
                if (c[4:0] == PRE_MAX) begin
                    r[15:8] = c[15:8] + 8'h01;
                    r[16] = &c[15:8]; // [RL14]
                end
            end
            MODE_16: r = {1'b0, c} + 17'h00001; // [RL16]
            MODE_8R: begin
                r[7:0] = (&c[7:0]) ? c[15:8] : c[7:0] + 8'h01; // [RL17]
                r[16] = &c[7:0];
            end
            default: begin
                r[7:0] = c[7:0] + 8'h01;
                r[16] = &c[7:0];
            end
        endcase
        return r;
    endfunction : dtc_step

    ////////////////////////////////////////////////////////////////////////////////
    // machine tick: free-running divide by twelve of the oscillator

    logic [3:0] div_q;
    logic tick_q;

    // nothing from the processor side can stretch this divider
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            div_q <= 4'h0;
            tick_q <= 1'b0;
        end else begin
            div_q <= (div_q == TICK_LAST) ? 4'h0 : div_q + 4'h1; // [RL2]
            tick_q <= (div_q == TICK_LAST); // [RL1]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pins

    logic [NPIN-1:0] pins;
    logic [NPIN-1:0] lvl;
    logic [NPIN-1:0] lvl_fell;
    logic [NPIN-1:0] smp_fell;

    assign pins = {ext_irq_pin_one, ext_irq_pin_zero, count_pin_one, count_pin_zero};

    dtc_pin_sampler u_sampler (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .tick(tick_q),
        .pins(pins),
        .lvl(lvl),
        .lvl_fell(lvl_fell),
        .smp_fell(smp_fell)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // registers and decode

    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic [7:0] mode_q;
    logic [15:0] cnt0_q;
    logic [15:0] cnt0_d;
    logic [15:0] cnt1_q;
    logic [15:0] cnt1_d;

    logic wr_ctrl;
    logic wr_mode;
    logic wr_t0l;
    logic wr_t0h;
    logic wr_t1l;
    logic wr_t1h;
    logic [7:0] rd_mux;

    assign wr_ctrl = sfr_req.wr && (sfr_req.addr == ADDR_CTRL);
    assign wr_mode = sfr_req.wr && (sfr_req.addr == ADDR_MODE);
    assign wr_t0l = sfr_req.wr && (sfr_req.addr == ADDR_T0L);
    assign wr_t0h = sfr_req.wr && (sfr_req.addr == ADDR_T0H);
    assign wr_t1l = sfr_req.wr && (sfr_req.addr == ADDR_T1L);
    assign wr_t1h = sfr_req.wr && (sfr_req.addr == ADDR_T1H);

    assign rd_mux = (sfr_req.addr == ADDR_CTRL) ? ctrl_q :
                    (sfr_req.addr == ADDR_MODE) ? mode_q :
                    (sfr_req.addr == ADDR_T0L) ? cnt0_q[7:0] :
                    (sfr_req.addr == ADDR_T0H) ? cnt0_q[15:8] :
                    (sfr_req.addr == ADDR_T1L) ? cnt1_q[7:0] :
                    (sfr_req.addr == ADDR_T1H) ? cnt1_q[15:8] : RD_UNMAPPED;

    ////////////////////////////////////////////////////////////////////////////////
    // count enables

    dtc_unit_cfg_t cfg0;
    dtc_unit_cfg_t cfg1;
    logic split0;
    logic stop1;
    logic run0;
    logic run1;
    logic src0;
    logic src1;
    logic en0;
    logic en1;
    logic enh0;
    logic [16:0] step0;
    logic [16:0] step1;
    logic ovf0;
    logic ovf1;
    logic ovfh;

    assign cfg0 = dtc_unit_cfg_t'(mode_q[CFG0_LSB +: 4]);
    assign cfg1 = dtc_unit_cfg_t'(mode_q[CFG1_LSB +: 4]);
    assign split0 = (cfg0.mode == MODE_SPLIT); // [RL12]
    assign stop1 = (cfg1.mode == MODE_SPLIT); // [RL18]

    assign run0 = ctrl_q[B_TR0] & (~cfg0.gate | lvl[PIN_INT0]); // [RL7] [RL10]
    // while unit 0 is split, unit 1 loses its run bit and is switched by its mode
    assign run1 = (split0 | ctrl_q[B_TR1]) & (~cfg1.gate | lvl[PIN_INT1]); // [RL10] [RL20]
    assign src0 = cfg0.count_sel ? smp_fell[PIN_C0] : 1'b1; // [RL11] [RL3]
    assign src1 = cfg1.count_sel ? smp_fell[PIN_C1] : 1'b1; // [RL11] [RL3]
    assign en0 = tick_q & run0 & src0; // [RL1] [RL4]
    assign en1 = tick_q & run1 & src1 & ~stop1; // [RL18]
    assign enh0 = tick_q & split0 & ctrl_q[B_TR1]; // [RL19]

    assign step0 = dtc_step(cfg0.mode, cnt0_q);
    assign step1 = dtc_step(cfg1.mode, cnt1_q);
    assign ovf0 = en0 & step0[16];
    assign ovf1 = en1 & step1[16];
    assign ovfh = enh0 & (&cnt0_q[15:8]);

    // software byte writes win over a count in the same cycle
    always_comb begin
        cnt0_d = cnt0_q;
        if (en0) begin
            cnt0_d = step0[15:0];
        end
        if (enh0) begin
            cnt0_d[15:8] = cnt0_q[15:8] + 8'h01; // [RL19]
        end
        if (wr_t0l) begin
            cnt0_d[7:0] = sfr_req.data;
        end
        if (wr_t0h) begin
            cnt0_d[15:8] = sfr_req.data;
        end
    end

    always_comb begin
        cnt1_d = cnt1_q;
        if (en1) begin
            cnt1_d = step1[15:0];
        end
        if (wr_t1l) begin
            cnt1_d[7:0] = sfr_req.data;
        end
        if (wr_t1h) begin
            cnt1_d[15:8] = sfr_req.data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // control flags: hardware set wins over service clear

    logic set_tf0;
    logic set_tf1;
    logic set_ie0;
    logic set_ie1;

    assign set_tf0 = ovf0; // [RL6]
    assign set_tf1 = split0 ? ovfh : ovf1; // [RL19]
    assign set_ie0 = ctrl_q[B_IT0] ? lvl_fell[PIN_INT0] : ~lvl[PIN_INT0]; // [RL9]
    assign set_ie1 = ctrl_q[B_IT1] ? lvl_fell[PIN_INT1] : ~lvl[PIN_INT1]; // [RL9]

    assign ctrl_d[B_TF1] = set_tf1 | (ctrl_q[B_TF1] & ~t1_irq_ack); // [RL6]
    assign ctrl_d[B_TF0] = set_tf0 | (ctrl_q[B_TF0] & ~t0_irq_ack); // [RL6]
    assign ctrl_d[B_IE1] = set_ie1 | (ctrl_q[B_IE1] & ~ext1_irq_ack); // [RL8]
    assign ctrl_d[B_IE0] = set_ie0 | (ctrl_q[B_IE0] & ~ext0_irq_ack); // [RL8]
    assign ctrl_d[B_TR1] = wr_ctrl ? sfr_req.data[B_TR1] : ctrl_q[B_TR1];
    assign ctrl_d[B_TR0] = wr_ctrl ? sfr_req.data[B_TR0] : ctrl_q[B_TR0];
    assign ctrl_d[B_IT1] = wr_ctrl ? sfr_req.data[B_IT1] : ctrl_q[B_IT1];
    assign ctrl_d[B_IT0] = wr_ctrl ? sfr_req.data[B_IT0] : ctrl_q[B_IT0];

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= CTRL_RST;
            mode_q <= MODE_RST;
            cnt0_q <= CNT_RST;
            cnt1_q <= CNT_RST;
        end else begin
            ctrl_q <= ctrl_d;
            mode_q <= wr_mode ? sfr_req.data : mode_q;
            cnt0_q <= cnt0_d; // [RL15]
            cnt1_q <= cnt1_d;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data_q <= RD_UNMAPPED;
            t0_ovf_pulse_q <= 1'b0;
            t1_ovf_pulse_q <= 1'b0;
        end else begin
            rd_data_q <= sfr_req.rd ? rd_mux : rd_data_q;
            t0_ovf_pulse_q <= ovf0;
            // unit 1 overflow still pulses while split, e.g. for a baud source
            t1_ovf_pulse_q <= ovf1; // [RL20]
        end
    end

    assign t0_overflow_flag = ctrl_q[B_TF0];
    assign t1_overflow_flag = ctrl_q[B_TF1];
    assign ext_irq0_flag = ctrl_q[B_IE0];
    assign ext_irq1_flag = ctrl_q[B_IE1];

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    a_tick_every_twelve: assert property ( // [RL1]
        tick_q |=> (!tick_q)[*8] ##1 (!tick_q)[*3] ##1 tick_q)
        else $error("machine tick not every twelve clocks");

    a_run_off_holds: assert property ( // [RL7]
        !ctrl_q[B_TR0] && !split0 && !wr_t0l && !wr_t0h |=> cnt0_q == $past(cnt0_q))
        else $error("unit 0 counted with run bit clear");

    a_gate_blocks: assert property ( // [RL10]
        cfg0.gate && !lvl[PIN_INT0] && !split0 && !wr_t0l && !wr_t0h
        |=> cnt0_q == $past(cnt0_q))
        else $error("gated unit 0 counted with pin low");

    a_edge_counts: assert property ( // [RL3]
        en0 && cfg0.count_sel && cfg0.mode == MODE_16 && !wr_t0l && !wr_t0h
        |=> cnt0_q == $past(cnt0_q) + 16'h0001 ##1 !smp_fell[PIN_C0])
        else $error("sampled fall not counted once");

    a_ovf_flag_set: assert property ( // [RL14]
        en1 && !split0 && cfg1.mode == MODE_13 && cnt1_q[15:8] == 8'hff && cnt1_q[4:0] == PRE_MAX
        && !wr_t1l && !wr_t1h |=> ctrl_q[B_TF1] && cnt1_q[4:0] == 5'h00)
        else $error("13-bit rollover did not set flag");

    a_flag_svc_clear: assert property ( // [RL6]
        t1_irq_ack && !set_tf1 |=> !ctrl_q[B_TF1])
        else $error("overflow flag not cleared on service");

    a_reload_low: assert property ( // [RL17]
        en0 && cfg0.mode == MODE_8R && cnt0_q[7:0] == 8'hff && !wr_t0l && !wr_t0h
        |=> cnt0_q[7:0] == $past(cnt0_q[15:8]) && cnt0_q[15:8] == $past(cnt0_q[15:8]))
        else $error("reload from high byte failed");

    a_unit1_stop: assert property ( // [RL18]
        stop1 && !wr_t1l && !wr_t1h |=> $stable(cnt1_q))
        else $error("unit 1 moved in stop mode");

    a_edge_irq_set: assert property ( // [RL9]
        ctrl_q[B_IT0] && lvl_fell[PIN_INT0] && !wr_ctrl |=> ctrl_q[B_IE0])
        else $error("falling edge did not set flag");

    a_split_high: assert property ( // [RL19]
        enh0 && cnt0_q[15:8] == 8'hff && !wr_t0h |=> ctrl_q[B_TF1] && cnt0_q[15:8] == 8'h00)
        else $error("split high byte overflow missed");

endmodule : dtc_timer_pair
`default_nettype wire

/* bench/dtc_pin_model.sv */
// dtc_pin_model: far-side source of count pulses and gate/interrupt pin levels
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_model (
    input wire logic core_clk,
    input wire logic go,
    input wire logic [7:0] n,
    input wire logic [7:0] half,
    input wire logic [1:0] ext_lvl,
    output logic count_pin_zero,
    output logic count_pin_one,
    output logic ext_irq_pin_zero,
    output logic ext_irq_pin_one,
    output logic busy
);
    logic pin = 1'b1;
    logic [7:0] rem = 8'h00;
    logic [7:0] t = 8'h00;
    ////////////////////////////////////////
    // each level lasts half clocks; callers keep half at 12 or more so no level is missed
    always @(posedge core_clk) begin
        if (go) begin
            rem <= n;
            t <= 8'h00;
        end else if (rem != 8'h00) begin
            if (t == half - 8'h01) begin
                t <= 8'h00;
                pin <= ~pin;
                if (pin == 1'b0) begin
                    rem <= rem - 8'h01;
                end
            end else begin
                t <= t + 8'h01;
            end
        end
    end
    // idle high between bursts, so a burst always starts with a falling edge
    assign count_pin_zero = pin;
    assign count_pin_one = pin;
    assign ext_irq_pin_zero = ext_lvl[0];
    assign ext_irq_pin_one = ext_lvl[1];
    assign busy = (rem != 8'h00);
endmodule : dtc_pin_model
`default_nettype wire

/* bench/dtc_timer_pair_test.sv */
// dtc_timer_pair_test: register-level tests of the dual timer/counter pair
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin checked++; if ((g) !== (e)) begin err_count++; \
    $display("mismatch %0t %s", $time, m); end end
module dtc_timer_pair_test import dtc_pkg::*;;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    dtc_sfr_req_t sfr_req = '0;
    logic [3:0] ack = 4'h0;
    logic go = 1'b0;
    logic [7:0] n = 8'h00;
    logic [7:0] half = 8'h0c;
    logic [1:0] ext_lvl = 2'h3;
    wire logic c0, c1, e0, e1, busy;
    wire logic [5:0] flg;
    logic [7:0] rd_data_q;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;
    int k;
    always #10 core_clk = ~core_clk;
    dtc_timer_pair uut (.core_clk(core_clk), .arst_n(arst_n), .sfr_req(sfr_req),
        .t0_irq_ack(ack[0]), .t1_irq_ack(ack[1]), .ext0_irq_ack(ack[2]), .ext1_irq_ack(ack[3]),
        .count_pin_zero(c0), .count_pin_one(c1), .ext_irq_pin_zero(e0), .ext_irq_pin_one(e1),
        .rd_data_q(rd_data_q), .t0_overflow_flag(flg[0]), .t1_overflow_flag(flg[1]),
        .ext_irq0_flag(flg[2]), .ext_irq1_flag(flg[3]), .t0_ovf_pulse_q(flg[4]),
        .t1_ovf_pulse_q(flg[5]));
    dtc_pin_model pins (.core_clk(core_clk), .go(go), .n(n), .half(half), .ext_lvl(ext_lvl),
        .count_pin_zero(c0), .count_pin_one(c1), .ext_irq_pin_zero(e0),
        .ext_irq_pin_one(e1), .busy(busy));
    ////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge core_clk);
        sfr_req = '{wr: 1'b1, rd: 1'b0, addr: a, data: v};
        @(negedge core_clk);
        sfr_req = '0;
    endtask : wr
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        @(negedge core_clk);
        sfr_req = '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
        @(negedge core_clk);
        sfr_req = '0;
        `CHK(rd_data_q, e, "read data")
    endtask : rchk
    task automatic waitf(input int i, input int lim);
        int c;
        c = 0;
        while (flg[i] !== 1'b1 && c < lim) begin
            @(negedge core_clk);
            c++;
        end
        `CHK(flg[i], 1'b1, "flag not raised")
    endtask : waitf
    task automatic do_ack(input logic [3:0] a);
        @(negedge core_clk);
        ack = a;
        @(negedge core_clk);
        ack = 4'h0;
    endtask : do_ack
    task automatic pulses(input logic [7:0] cnt, input logic [7:0] h);
        int c;
        @(negedge core_clk);
        n = cnt;
        half = h;
        go = 1'b1;
        @(negedge core_clk);
        go = 1'b0;
        c = 0;
        while (busy && c < 2000) begin
            @(negedge core_clk);
            c++;
        end
        // synchroniser plus two sample ticks before the last edge reaches the count
        repeat (40) @(negedge core_clk);
    endtask : pulses
    task automatic summarize;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : summarize
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            $display("mismatch %0t timeout", $time);
            summarize();
        end
    end
    ////////////////////////////////////////
    initial begin
        repeat (12) @(negedge core_clk);
        arst_n = 1'b1;
        rchk(ADDR_CTRL, CTRL_RST);
        rchk(ADDR_MODE, MODE_RST);
        rchk(8'h90, RD_UNMAPPED);
        wr(ADDR_CTRL, 8'haa);
        rchk(ADDR_CTRL, 8'h00);
        wr(ADDR_MODE, 8'h5a);
        rchk(ADDR_MODE, 8'h5a);
        $display("test regs done");
        wr(ADDR_MODE, 8'h02);
        wr(ADDR_T0H, 8'hfe);
        wr(ADDR_T0L, 8'hfe);
        wr(ADDR_CTRL, 8'h10);
        waitf(4, 40);
        k = 0;
        do begin
            @(negedge core_clk);
            k++;
        end while (flg[4] !== 1'b1 && k < 100);
        `CHK(k, 2 * TICK_DIV, "reload period")
        wr(ADDR_CTRL, 8'h00);
        rchk(ADDR_T0H, 8'hfe);
        `CHK(flg[0], 1'b1, "t0 flag")
        do_ack(4'h1);
        `CHK(flg[0], 1'b0, "t0 flag after ack")
        $display("test reload done");
        wr(ADDR_MODE, 8'h01);
        wr(ADDR_T1H, 8'hff);
        wr(ADDR_T1L, 8'hfe);
        wr(ADDR_T0H, 8'hff);
        wr(ADDR_T0L, 8'hfd);
        wr(ADDR_CTRL, 8'h50);
        waitf(1, 40);
        waitf(0, 20);
        wr(ADDR_CTRL, 8'h00);
        rchk(ADDR_T1L, 8'he1);
        rchk(ADDR_T1H, 8'h00);
        rchk(ADDR_T0L, 8'h00);
        rchk(ADDR_T0H, 8'h00);
        do_ack(4'h3);
        $display("test widths done");
        wr(ADDR_MODE, 8'h55);
        for (k = 0; k < 4; k++) wr(ADDR_T0L + 8'(k), 8'h00);
        wr(ADDR_CTRL, 8'h50);
        pulses(8'd5, 8'd12);
        rchk(ADDR_T0L, 8'h05);
        rchk(ADDR_T1L, 8'h05);
        pulses(8'd3, 8'd30);
        wr(ADDR_MODE, 8'h5d);
        @(negedge core_clk);
        ext_lvl = 2'b10;
        pulses(8'd3, 8'd12);
        `CHK(flg[2], 1'b1, "level flag")
        wr(ADDR_CTRL, 8'h00);
        pulses(8'd2, 8'd12);
        rchk(ADDR_T0L, 8'h08);
        rchk(ADDR_T1L, 8'h0b);
        @(negedge core_clk);
        ext_lvl = 2'b11;
        repeat (5) @(negedge core_clk);
        do_ack(4'h4);
        `CHK(flg[2], 1'b0, "level flag after ack")
        $display("test counter done");
        for (k = 0; k < 2; k++) begin
            wr(ADDR_CTRL, (k == 1) ? 8'h04 : 8'h01);
            @(negedge core_clk);
            ext_lvl[k] = 1'b0;
            waitf(2 + k, 10);
            do_ack(4'(4'h4 << k));
            `CHK(flg[2 + k], 1'b0, "edge flag after ack")
            wr(ADDR_CTRL, 8'h00);
            waitf(2 + k, 10);
            do_ack(4'(4'h4 << k));
            `CHK(flg[2 + k], 1'b1, "level flag held low")
            @(negedge core_clk);
            ext_lvl[k] = 1'b1;
            repeat (5) @(negedge core_clk);
            do_ack(4'(4'h4 << k));
            `CHK(flg[2 + k], 1'b0, "level flag released")
        end
        $display("test ext done");
        wr(ADDR_MODE, 8'h03);
        wr(ADDR_T0H, 8'hff);
        wr(ADDR_T0L, 8'h00);
        // unit 1 runs without its run bit while unit 0 is split; next tick rolls it over
        wr(ADDR_T1H, 8'hff);
        wr(ADDR_T1L, 8'hff);
        waitf(5, 40);
        `CHK(flg[1], 1'b0, "t1 flag from unit 1 in split")
        wr(ADDR_CTRL, 8'h40);
        waitf(1, 40);
        wr(ADDR_CTRL, 8'h00);
        `CHK(flg[0], 1'b0, "t0 flag in split")
        rchk(ADDR_T0L, 8'h00);
        rchk(ADDR_T0H, 8'h00);
        do_ack(4'h2);
        wr(ADDR_MODE, 8'h33);
        wr(ADDR_T1L, 8'h42);
        wr(ADDR_CTRL, 8'h40);
        repeat (40) @(negedge core_clk);
        rchk(ADDR_T1L, 8'h42);
        $display("test split done");
        summarize();
    end
endmodule : dtc_timer_pair_test
`default_nettype wire
